// ### rtl/sart_byte_ctr.v
// One 8-bit count byte with software load, advance and wrap reload
`timescale 1ns/10ps
`default_nettype none
`include "sart_map.vh"

module sart_byte_ctr
(
  input wire clock,
  input wire rst_n,
  input wire wr_en,
  input wire [7:0] wr_val,
  input wire adv,
  input wire reload_en,
  input wire [7:0] reload_val,
  output reg [7:0] cnt_q,
  output wire wrap
);

  assign wrap = adv && (cnt_q == `SART_BYTE_MAX);

  // A software write beats a count in the same cycle
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= `SART_RST_BYTE;
    else if (wr_en)
      cnt_q <= wr_val;
    else if (wrap)
      cnt_q <= reload_en ? reload_val : 8'h00;
    else if (adv)
      cnt_q <= cnt_q + 8'h01;
  end

endmodule
`default_nettype wire

// ### rtl/sart_map.vh
// Register map, field positions, reset values and divider counts of the split reload timer
//
// How it works
// - Timer is two 8-bit count bytes; split select picks 16-bit or two 8-bit.
// - Count clock is core clock, core clock over 12, or external oscillator over 8.
// - External oscillator over 8 is synchronised to the core clock before counting.
// - 16-bit mode: wrap from ffff reloads 16-bit value and sets high overflow flag.
// - 16-bit mode: with timer interrupt enabled, every 16-bit overflow requests interrupt.
// - 16-bit mode: with low interrupt enable too, low byte wraps also request interrupt.
// - Split mode: two independent 8-bit counters, each reloading from its own reload byte.
// - Split mode: run bit gates only the high byte; low byte always counts.
// - Split mode: high clock select 1 is core clock, else external select chooses source.
// - Split mode: low clock select 1 is core clock, else shared external select chooses.
// - Split mode: each byte wrap from ff to its reload byte sets its own overflow flag.
// - Split mode: interrupt on high wraps; with low enable, on either byte wrap.
// - Hardware never clears overflow flags; only a software write of zero does.
`ifndef SART_MAP_VH
`define SART_MAP_VH

// ==========================================================
// Register byte offsets
`define SART_OFF_CTRL 6'h00
`define SART_OFF_CLKSEL 6'h04
`define SART_OFF_CNT_LO 6'h08
`define SART_OFF_CNT_HI 6'h0c
`define SART_OFF_RLD_LO 6'h10
`define SART_OFF_RLD_HI 6'h14
`define SART_OFF_IRQ_STAT 6'h18
`define SART_OFF_IRQ_MASK 6'h1c
`define SART_OFF_IRQ_EN 6'h20

// ==========================================================
// Control register fields
`define SART_CTRL_HI_OVF 7
`define SART_CTRL_LO_OVF 6
`define SART_CTRL_LO_IRQ_EN 5
`define SART_CTRL_SPLIT 3
`define SART_CTRL_RUN 2
`define SART_CTRL_EXT_SEL 0
`define SART_CTRL_RMASK 8'hed

// Clock select register fields
`define SART_CLK_HI_SEL 5
`define SART_CLK_LO_SEL 4
`define SART_CLK_RMASK 8'h30

// Interrupt status and mask fields
`define SART_IRQ_HI 0
`define SART_IRQ_LO 1

// ==========================================================
// Reset values
`define SART_RST_BYTE 8'h00
`define SART_RST_MASK 2'h3

// ==========================================================
// Divider counts
`define SART_DIV_CORE 4'hc
`define SART_DIV_EXT 3'h7
`define SART_BYTE_MAX 8'hff

`endif

// ### rtl/sart_tick_gen.v
// Count-clock tick generator: core clock over 12 and synchronised external oscillator over 8
`timescale 1ns/10ps
`default_nettype none
`include "sart_map.vh"

module sart_tick_gen
(
  input wire clock,
  input wire rst_n,
  input wire ext_osc,
  output reg tick_div12_q,
  output reg tick_ext8_q
);

  reg [3:0] div12_q;
  reg [2:0] div8_q;
  reg ext_meta_q;
  reg ext_sync_q;
  reg ext_prev_q;
  wire ext_rise;

  assign ext_rise = ext_sync_q & ~ext_prev_q;

  // ==========================================================
  // Core clock divided by 12
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div12_q <= 4'h0;
      tick_div12_q <= 1'b0;
    end
    else
    begin
      tick_div12_q <= (div12_q == `SART_DIV_CORE - 4'h1);
      if (div12_q == `SART_DIV_CORE - 4'h1)
        div12_q <= 4'h0;
      else
        div12_q <= div12_q + 4'h1;
    end
  end

  // ==========================================================
  // External oscillator: synchronise, detect rising edges, divide by 8
  // Oscillator must run no faster than half the core clock or edges are lost
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      div8_q <= 3'h0;
      tick_ext8_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= ext_osc;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      tick_ext8_q <= ext_rise && (div8_q == `SART_DIV_EXT);
      if (ext_rise)
        div8_q <= div8_q + 3'h1;
    end
  end

endmodule
`default_nettype wire

// ### rtl/sart_top.v
// Split auto-reload timer with Avalon-MM register slave and interrupt output
`timescale 1ns/10ps
`default_nettype none
`include "sart_map.vh"

module sart_top
(
  input wire clock,
  input wire reset_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire ext_osc,
  output reg irq
);

  // ==========================================================
  // Reset synchroniser
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ==========================================================
  // Register state
  reg high_ovf_flag_q;
  reg low_ovf_flag_q;
  reg low_ovf_irq_en_q;
  reg split_mode_sel_q;
  reg run_control_bit_q;
  reg ext_clk_sel_q;
  reg high_clk_sel_q;
  reg low_clk_sel_q;
  reg [7:0] reload_low_byte_q;
  reg [7:0] reload_high_byte_q;
  reg timer_irq_enable_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;

  reg [1:0] irq_stat_d;
  reg high_ovf_flag_d;
  reg low_ovf_flag_d;

  wire tick_div12;
  wire tick_ext8;
  wire [7:0] count_low_byte;
  wire [7:0] count_high_byte;
  wire low_wrap;
  wire high_wrap;

  // ==========================================================
  // Bus handshake
  // Every access stalls one cycle: the register answer comes from a flop
  wire req;
  wire commit;
  wire wr_commit;
  wire lane0;

  assign req = avs_read | avs_write;
  assign commit = req & ~avs_waitrequest;
  assign wr_commit = commit & avs_write & lane0;
  assign lane0 = avs_byteenable[0];

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if (req && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // ==========================================================
  // Address decode
  function wr_hit;
    input [5:0] addr;
    input [5:0] offs;
    input wen;
    begin
      wr_hit = wen && (addr == offs);
    end
  endfunction

  wire wr_ctrl;
  wire wr_clksel;
  wire wr_cnt_lo;
  wire wr_cnt_hi;
  wire wr_rld_lo;
  wire wr_rld_hi;
  wire wr_stat;
  wire wr_mask;
  wire wr_irq_en;

  assign wr_ctrl = wr_hit(avs_address, `SART_OFF_CTRL, wr_commit);
  assign wr_clksel = wr_hit(avs_address, `SART_OFF_CLKSEL, wr_commit);
  assign wr_cnt_lo = wr_hit(avs_address, `SART_OFF_CNT_LO, wr_commit);
  assign wr_cnt_hi = wr_hit(avs_address, `SART_OFF_CNT_HI, wr_commit);
  assign wr_rld_lo = wr_hit(avs_address, `SART_OFF_RLD_LO, wr_commit);
  assign wr_rld_hi = wr_hit(avs_address, `SART_OFF_RLD_HI, wr_commit);
  assign wr_stat = wr_hit(avs_address, `SART_OFF_IRQ_STAT, wr_commit);
  assign wr_mask = wr_hit(avs_address, `SART_OFF_IRQ_MASK, wr_commit);
  assign wr_irq_en = wr_hit(avs_address, `SART_OFF_IRQ_EN, wr_commit);

  // ==========================================================
  // Count clock selection
  function sel_tick;
    input core_sel;
    input ext_sel;
    input t12;
    input t8;
    begin
      if (core_sel)
        sel_tick = 1'b1;
      else if (ext_sel)
        sel_tick = t8;
      else
        sel_tick = t12;
    end
  endfunction

  sart_tick_gen u_tick
  (
    .clock(clock),
    .rst_n(rst_n),
    .ext_osc(ext_osc),
    .tick_div12_q(tick_div12),
    .tick_ext8_q(tick_ext8)
  );

  wire low_tick;
  wire high_tick;
  wire low_adv;
  wire high_adv;
  wire low_reload_en;
  wire full_wrap;

  // In 16-bit mode the low select drives the whole counter
  assign low_tick = sel_tick(low_clk_sel_q, ext_clk_sel_q, tick_div12, tick_ext8);
  assign high_tick = sel_tick(high_clk_sel_q, ext_clk_sel_q, tick_div12, tick_ext8);

  // Split: low always runs, high is gated by run; 16-bit: run gates both
  assign low_adv = split_mode_sel_q ? low_tick : (low_tick & run_control_bit_q);
  assign high_adv = split_mode_sel_q ? (high_tick & run_control_bit_q) : low_wrap;

  // Low byte reloads only on its own wrap in split, or with the full wrap in 16-bit
  assign full_wrap = ~split_mode_sel_q & high_wrap;
  assign low_reload_en = split_mode_sel_q | full_wrap;

  // ==========================================================
  // The two count bytes
  wire [1:0] byte_wr;
  wire [7:0] byte_wval [0:1];
  wire [1:0] byte_adv;
  wire [1:0] byte_rld_en;
  wire [7:0] byte_rld [0:1];
  wire [7:0] byte_cnt [0:1];
  wire [1:0] byte_wrap;

  assign byte_wr = {wr_cnt_hi, wr_cnt_lo};
  assign byte_wval[0] = avs_writedata[7:0];
  assign byte_wval[1] = avs_writedata[7:0];
  assign byte_adv = {high_adv, low_adv};
  assign byte_rld_en = {1'b1, low_reload_en};
  assign byte_rld[0] = reload_low_byte_q;
  assign byte_rld[1] = reload_high_byte_q;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_byte
      sart_byte_ctr u_ctr
      (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(byte_wr[gi]),
        .wr_val(byte_wval[gi]),
        .adv(byte_adv[gi]),
        .reload_en(byte_rld_en[gi]),
        .reload_val(byte_rld[gi]),
        .cnt_q(byte_cnt[gi]),
        .wrap(byte_wrap[gi])
      );
    end
  endgenerate

  assign count_low_byte = byte_cnt[0];
  assign count_high_byte = byte_cnt[1];
  assign low_wrap = byte_wrap[0];
  assign high_wrap = byte_wrap[1];

  // ==========================================================
  // Overflow flags: hardware sets, only software clears, set wins
  always @*
  begin
    high_ovf_flag_d = high_ovf_flag_q;
    low_ovf_flag_d = low_ovf_flag_q;
    if (wr_ctrl)
    begin
      high_ovf_flag_d = avs_writedata[`SART_CTRL_HI_OVF];
      low_ovf_flag_d = avs_writedata[`SART_CTRL_LO_OVF];
    end
    if (high_wrap)
      high_ovf_flag_d = 1'b1;
    if (low_wrap)
      low_ovf_flag_d = 1'b1;
  end

  // ==========================================================
  // Interrupt events: sticky, write one to clear, set wins
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (wr_stat)
      irq_stat_d = irq_stat_q & ~avs_writedata[1:0];
    if (high_wrap)
      irq_stat_d[`SART_IRQ_HI] = 1'b1;
    if (low_wrap)
      irq_stat_d[`SART_IRQ_LO] = 1'b1;
  end

  // ==========================================================
  // Control and configuration registers
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_ovf_flag_q <= 1'b0;
      low_ovf_flag_q <= 1'b0;
      low_ovf_irq_en_q <= 1'b0;
      split_mode_sel_q <= 1'b0;
      run_control_bit_q <= 1'b0;
      ext_clk_sel_q <= 1'b0;
      high_clk_sel_q <= 1'b0;
      low_clk_sel_q <= 1'b0;
      reload_low_byte_q <= `SART_RST_BYTE;
      reload_high_byte_q <= `SART_RST_BYTE;
      timer_irq_enable_q <= 1'b0;
      irq_stat_q <= 2'h0;
      irq_mask_q <= `SART_RST_MASK;
    end
    else
    begin
      high_ovf_flag_q <= high_ovf_flag_d;
      low_ovf_flag_q <= low_ovf_flag_d;
      irq_stat_q <= irq_stat_d;
      if (wr_ctrl)
      begin
        low_ovf_irq_en_q <= avs_writedata[`SART_CTRL_LO_IRQ_EN];
        split_mode_sel_q <= avs_writedata[`SART_CTRL_SPLIT];
        run_control_bit_q <= avs_writedata[`SART_CTRL_RUN];
        ext_clk_sel_q <= avs_writedata[`SART_CTRL_EXT_SEL];
      end
      if (wr_clksel)
      begin
        high_clk_sel_q <= avs_writedata[`SART_CLK_HI_SEL];
        low_clk_sel_q <= avs_writedata[`SART_CLK_LO_SEL];
      end
      if (wr_rld_lo)
        reload_low_byte_q <= avs_writedata[7:0];
      if (wr_rld_hi)
        reload_high_byte_q <= avs_writedata[7:0];
      if (wr_mask)
        irq_mask_q <= avs_writedata[1:0];
      if (wr_irq_en)
        timer_irq_enable_q <= avs_writedata[0];
    end
  end

  // ==========================================================
  // Interrupt output
  // High events always count; low events only with the low enable set
  wire irq_d;

  assign irq_d = timer_irq_enable_q &
    ((irq_stat_q[`SART_IRQ_HI] & irq_mask_q[`SART_IRQ_HI]) |
     (irq_stat_q[`SART_IRQ_LO] & irq_mask_q[`SART_IRQ_LO] & low_ovf_irq_en_q));

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= irq_d;
  end

  // ==========================================================
  // Read data
  // Flags read back so software can tell the two sources apart
  reg [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    if (avs_address == `SART_OFF_CTRL)
      rd_byte = {high_ovf_flag_q, low_ovf_flag_q, low_ovf_irq_en_q, 1'b0,
                 split_mode_sel_q, run_control_bit_q, 1'b0, ext_clk_sel_q};
    else if (avs_address == `SART_OFF_CLKSEL)
      rd_byte = {2'h0, high_clk_sel_q, low_clk_sel_q, 4'h0};
    else if (avs_address == `SART_OFF_CNT_LO)
      rd_byte = count_low_byte;
    else if (avs_address == `SART_OFF_CNT_HI)
      rd_byte = count_high_byte;
    else if (avs_address == `SART_OFF_RLD_LO)
      rd_byte = reload_low_byte_q;
    else if (avs_address == `SART_OFF_RLD_HI)
      rd_byte = reload_high_byte_q;
    else if (avs_address == `SART_OFF_IRQ_STAT)
      rd_byte = {6'h00, irq_stat_q};
    else if (avs_address == `SART_OFF_IRQ_MASK)
      rd_byte = {6'h00, irq_mask_q};
    else if (avs_address == `SART_OFF_IRQ_EN)
      rd_byte = {7'h00, timer_irq_enable_q};
  end

  // Data is sampled while the stall is raised, so it stands at the accepting edge
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= {24'h000000, rd_byte};
  end

endmodule
`default_nettype wire

// ### sim/sart_chk.sv
// Concurrent checks on the register bus and interrupt output of the split reload timer
`timescale 1ns/10ps
`default_nettype none
`include "sart_map.vh"

// ==========================================================
// Checker
module sart_chk
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ext_osc,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic acc = avs_read || avs_write;
  wire logic rd_take = avs_read && avs_waitrequest;
  wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];

  a_wait_answer:
  assert property (acc && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single:
  assert property ($fell(avs_waitrequest) |=> $rose(avs_waitrequest))
    else $error("waitrequest low for more than one cycle");
  a_no_spurious:
  assert property (!acc |=> avs_waitrequest)
    else $error("answer without a request");
  a_read_upper:
  assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_unmapped_zero:
  assert property (rd_take && avs_address == 6'h24 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_reserved:
  assert property (rd_take && avs_address == `SART_OFF_CTRL
    |=> avs_readdata[4] == 1'b0 && avs_readdata[1] == 1'b0)
    else $error("unused control bits read as one");
  a_rdata_stands:
  assert property (!rd_take |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_irq_disable:
  assert property (wr_done && avs_address == `SART_OFF_IRQ_EN && !avs_writedata[0]
    |=> ##1 !irq)
    else $error("irq stayed high after disable");
  a_irq_masked:
  assert property (wr_done && avs_address == `SART_OFF_IRQ_MASK
    && avs_writedata[1:0] == 2'h0 |=> ##1 !irq)
    else $error("irq stayed high after full mask");
endmodule

bind sart_top sart_chk sart_chk_inst (.clock(clock), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ext_osc(ext_osc), .irq(irq));
`default_nettype wire

// ### sim/tb_sart_top.sv
// Self-checking testbench for the split reload timer
`timescale 1ns/10ps
`default_nettype none
`include "sart_map.vh"

// ==========================================================
// Bench
module tb_sart_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_osc = 1'b0;
  logic irq;
  integer error_cnt = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer osc_div = 0;
  logic [7:0] v;

  always #10 clock = ~clock;

  sart_top sart_top_inst (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_osc(ext_osc), .irq(irq));

  // Oscillator at a sixth of the core rate, so eight rising edges span 48 cycles
  always @(posedge clock)
  begin
    osc_div <= (osc_div == 2) ? 0 : osc_div + 1;
    if (osc_div == 2)
      ext_osc <= ~ext_osc;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end

  // ==========================================================
  // Shared tasks
  task summarize;
  begin
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask

  task ack;
  begin
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
  end
  endtask

  task wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] be = 4'hf);
  begin
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    ack;
    avs_write <= 1'b0;
  end
  endtask

  task rd(input logic [5:0] a, output logic [7:0] d);
  begin
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    ack;
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  end
  endtask

  task rc(input logic [5:0] a, input logic [7:0] e, input string nm);
  begin
    rd(a, v);
    chk(nm, {24'h0, e}, {24'h0, v});
  end
  endtask

  task wait_irq(input logic lvl, input integer lim, input string nm);
    integer n;
  begin
    n = 0;
    while (irq !== lvl && n < lim)
    begin
      @(posedge clock);
      n = n + 1;
    end
    chk(nm, {31'h0, lvl}, {31'h0, irq});
  end
  endtask

  task do_reset;
  begin
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
  end
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    integer i;
  begin
    for (i = 0; i < 9; i = i + 1)
      rc(6'(i * 4), (i == 7) ? 8'h03 : 8'h00, "reset value");
    wr(`SART_OFF_CNT_LO, 8'h55, 4'he);
    rc(`SART_OFF_CNT_LO, 8'h00, "lane off write");
    rc(6'h24, 8'h00, "unmapped read");
    wr(`SART_OFF_CNT_LO, 8'h55);
    rc(`SART_OFF_CNT_LO, 8'h55, "count write");
  end
  endtask

  task t_wrap16;
  begin
    wr(`SART_OFF_IRQ_STAT, 8'h03);
    wr(`SART_OFF_CLKSEL, 8'h10);
    wr(`SART_OFF_RLD_LO, 8'h34);
    wr(`SART_OFF_RLD_HI, 8'h12);
    wr(`SART_OFF_CNT_HI, 8'hff);
    wr(`SART_OFF_CNT_LO, 8'hf0);
    wr(`SART_OFF_IRQ_EN, 8'h01);
    wr(`SART_OFF_CTRL, 8'h04);
    wait_irq(1'b1, 40, "irq on 16-bit wrap");
    rc(`SART_OFF_CTRL, 8'hc4, "flags after wrap");
    rc(`SART_OFF_CNT_HI, 8'h12, "reloaded high byte");
    rc(`SART_OFF_IRQ_STAT, 8'h03, "status after wrap");
    wr(`SART_OFF_IRQ_STAT, 8'h03);
    wait_irq(1'b0, 4, "irq after status clear");
    rc(`SART_OFF_CTRL, 8'hc4, "flags kept");
    wr(`SART_OFF_CTRL, 8'h00);
    rc(`SART_OFF_CTRL, 8'h00, "flags cleared");
    rd(`SART_OFF_CNT_LO, v);
    rc(`SART_OFF_CNT_LO, v, "stopped count");
    wr(`SART_OFF_IRQ_EN, 8'h00);
  end
  endtask

  task t_low16;
  begin
    wr(`SART_OFF_IRQ_STAT, 8'h03);
    wr(`SART_OFF_IRQ_EN, 8'h01);
    wr(`SART_OFF_CNT_HI, 8'h00);
    wr(`SART_OFF_CNT_LO, 8'hfe);
    wr(`SART_OFF_CTRL, 8'h04);
    repeat (20) @(posedge clock);
    chk("irq without low enable", 32'h0, {31'h0, irq});
    rc(`SART_OFF_CTRL, 8'h44, "low flag in 16-bit");
    wr(`SART_OFF_CTRL, 8'h24);
    wait_irq(1'b1, 4, "irq with low enable");
    wr(`SART_OFF_IRQ_MASK, 8'h00);
    wait_irq(1'b0, 4, "masked irq");
    wr(`SART_OFF_IRQ_MASK, 8'h03);
    wr(`SART_OFF_CTRL, 8'h00);
    wr(`SART_OFF_IRQ_STAT, 8'h03);
    wr(`SART_OFF_IRQ_EN, 8'h00);
  end
  endtask

  task t_split;
  begin
    wr(`SART_OFF_CTRL, 8'h08);
    wr(`SART_OFF_CLKSEL, 8'h30);
    wr(`SART_OFF_RLD_LO, 8'ha0);
    wr(`SART_OFF_RLD_HI, 8'h50);
    wr(`SART_OFF_CNT_HI, 8'hfd);
    wr(`SART_OFF_CNT_LO, 8'hfd);
    repeat (10) @(posedge clock);
    rc(`SART_OFF_CNT_HI, 8'hfd, "gated high byte");
    rd(`SART_OFF_CNT_LO, v);
    chk("low reload", 32'h1, {31'h0, v >= 8'ha0 && v < 8'hc0});
    rc(`SART_OFF_CTRL, 8'h48, "low flag only");
    wr(`SART_OFF_IRQ_EN, 8'h01);
    repeat (2) @(posedge clock);
    chk("low wrap without enable", 32'h0, {31'h0, irq});
    wr(`SART_OFF_CTRL, 8'h4c);
    repeat (8) @(posedge clock);
    rc(`SART_OFF_CTRL, 8'hcc, "high flag set");
    rd(`SART_OFF_CNT_HI, v);
    chk("high reload", 32'h1, {31'h0, v >= 8'h50 && v < 8'h60});
    wait_irq(1'b1, 4, "split high irq");
    // High byte stopped so only a low wrap can raise the request
    wr(`SART_OFF_CTRL, 8'h28);
    wr(`SART_OFF_IRQ_STAT, 8'h03);
    wait_irq(1'b0, 4, "split status clear");
    wait_irq(1'b1, 300, "split low irq");
    rc(`SART_OFF_IRQ_STAT, 8'h02, "low source only");
  end
  endtask

  task t_rate(input logic [7:0] ctl, input integer wt, input string nm);
  begin
    // Source select held for the whole window so only that source moves the low byte
    wr(`SART_OFF_CTRL, ctl & 8'hfb);
    wr(`SART_OFF_CLKSEL, 8'h00);
    wr(`SART_OFF_IRQ_EN, 8'h00);
    wr(`SART_OFF_CNT_HI, 8'h00);
    wr(`SART_OFF_CNT_LO, 8'h00);
    wr(`SART_OFF_CTRL, ctl);
    repeat (wt) @(posedge clock);
    wr(`SART_OFF_CTRL, ctl & 8'hfb);
    rd(`SART_OFF_CNT_HI, v);
    chk(nm, 32'h1, {31'h0, v >= 8'd9 && v <= 8'd11});
    rd(`SART_OFF_CNT_LO, v);
    chk(nm, 32'h1, {31'h0, v >= 8'd9 && v <= 8'd12});
  end
  endtask

  initial
  begin
    do_reset;
    t_regs;
    t_wrap16;
    t_low16;
    t_split;
    t_rate(8'h0c, 120, "core over twelve");
    t_rate(8'h0d, 480, "external over eight");
    do_reset;
    t_regs;
    summarize;
  end
endmodule
`default_nettype wire
